// File: rtl/iop_pkg.sv
// Purpose: Shared constants and types for the I/O port and core control block.
// Assumes: Byte-wide data-space bus with a short I/O space offset by a fixed amount.
// Notes: Port B pin input register is included since ports A and B share the scheme.
package iop_pkg;
  // --------------------------------------------------------------------------
  // Address map
  // --------------------------------------------------------------------------
  localparam logic [7:0] IOP_IO_OFFSET = 8'h20;
  localparam logic [7:0] IOP_IO_TOP = 8'h3F;
  localparam logic [7:0] IOP_PORT_A_PIN_INPUT = 8'h20;
  localparam logic [7:0] IOP_PORT_A_DIRECTION = 8'h21;
  localparam logic [7:0] IOP_PORT_A_OUTPUT_LATCH = 8'h22;
  localparam logic [7:0] IOP_PORT_B_PIN_INPUT = 8'h23;
  localparam logic [7:0] IOP_PORT_B_DIRECTION = 8'h24;
  localparam logic [7:0] IOP_PORT_B_OUTPUT_LATCH = 8'h25;
  localparam logic [7:0] IOP_CORE_CONTROL = 8'h55;
  // --------------------------------------------------------------------------
  // Core control fields and reset values
  // --------------------------------------------------------------------------
  localparam int IOP_BIT_DEBUG_PORT_DISABLE = 7;
  localparam int IOP_BIT_BROWNOUT_SLEEP_OFF = 6;
  localparam int IOP_BIT_BROWNOUT_SLEEP_OFF_UNLOCK = 5;
  localparam int IOP_BIT_GLOBAL_PULLUP_OFF = 4;
  localparam int IOP_BIT_VECTOR_TABLE_SELECT = 1;
  localparam int IOP_BIT_VECTOR_CHANGE_UNLOCK = 0;
  localparam logic [7:0] IOP_PORT_RESET = 8'h00;
  localparam logic [7:0] IOP_CTRL_RESET = 8'h00;
  // --------------------------------------------------------------------------
  // Timing counts in clock cycles
  // --------------------------------------------------------------------------
  localparam logic [2:0] IOP_UNLOCK_CYCLES = 3'h4;
  localparam logic [2:0] IOP_SOFF_DELAY_CYCLES = 3'h3;
  localparam logic [2:0] IOP_SOFF_ACTIVE_CYCLES = 3'h3;
  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic wr;
    logic io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iop_bus_s;
  typedef struct packed {
    logic [7:0] direction;
    logic [7:0] output_latch;
    logic [7:0] pins_in;
  } iop_port_s;
endpackage

// File: rtl/iop_sync.sv
// Purpose: Two flip-flop synchroniser for a byte of port pins.
// Assumes: Pins are asynchronous to clock.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module iop_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } iop_sync_state_s;
  iop_sync_state_s state_reg;
  iop_sync_state_s state_next;

  // Shift the pins through the two stages.
  always_comb begin
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  // Register the stages.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;
endmodule // iop_sync
`default_nettype wire

// File: rtl/iop_regs.sv
// Purpose: Port A/B registers and the core control register with timed writes.
// Assumes: One bus access per cycle; reads return data one cycle after req.
// Notes: Pull-up, pad drive and control outputs come from flip-flops, except irq_block, whose lock terms are combinational.
`timescale 1ns/1ps
`default_nettype none
module iop_regs #(
  parameter int ADDR_W = 16,
  parameter logic [ADDR_W-1:0] BOOT_START = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire iop_pkg::iop_bus_s bus,
  output logic [7:0] rdata,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_a_pullup,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_pullup,
  input wire logic debug_port_fuse,
  output logic debug_port_enable,
  input wire logic sleep_exec,
  output logic brownout_sleep_off_active,
  output logic brownout_detector_off,
  output logic [ADDR_W-1:0] vector_base,
  input wire logic app_lock_bit,
  input wire logic boot_lock_bit,
  input wire logic exec_in_boot,
  input wire logic instr_done,
  output logic irq_block
);
  import iop_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    IOP_VEC_IDLE = 2'b00,
    IOP_VEC_OPEN = 2'b01,
    IOP_VEC_TAIL = 2'b10
  } iop_vec_e;

  typedef struct packed {
    iop_port_s port_a;
    iop_port_s port_b;
    logic debug_port_disable;
    logic [7:0] debug_wval;
    logic [2:0] debug_win;
    logic brownout_sleep_off;
    logic brownout_sleep_off_unlock;
    logic [2:0] soff_unlock_win;
    logic [2:0] soff_delay;
    logic [2:0] soff_active_cnt;
    logic soff_active;
    logic detector_off;
    logic global_pullup_off;
    logic vector_table_select;
    logic vector_change_unlock;
    iop_vec_e vec_state;
    logic [2:0] vec_win;
    logic [7:0] rdata;
    logic [7:0] a_pullup;
    logic [7:0] b_pullup;
    logic debug_en;
  } iop_state_s;

  iop_state_s state_reg;
  iop_state_s state_next;
  logic [7:0] a_pins_sync;
  logic [7:0] b_pins_sync;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Map an access onto its data-space address; I/O space adds the offset.
  // A short address above the I/O range falls onto an unmapped address.
  function automatic logic [7:0] iop_decode(input logic io_space, input logic [7:0] addr);
    logic [7:0] a;
    a = 8'h00;
    if (io_space) begin
      a = (addr <= IOP_IO_TOP) ? 8'(addr + IOP_IO_OFFSET) : 8'h00;
    end else begin
      a = addr;
    end
    return a;
  endfunction

  // Pull-up is on for input pins with the latch high, unless globally off.
  function automatic logic [7:0] iop_pullup(input logic [7:0] dir, input logic [7:0] lat, input logic off);
    return off ? 8'h00 : (~dir & lat);
  endfunction

  // Count a window down to zero.
  function automatic logic [2:0] iop_dec(input logic [2:0] v);
    return (v == 3'h0) ? 3'h0 : 3'(v - 3'h1);
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  iop_sync #(.WIDTH(8)) u_sync_a (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(port_a_pins),
    .sync_out(a_pins_sync)
  );
  iop_sync #(.WIDTH(8)) u_sync_b (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(port_b_pins),
    .sync_out(b_pins_sync)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  // Register writes, timed sequences and read data.
  always_comb begin
    logic [7:0] addr;
    logic wr;
    logic wr_ctrl;
    logic [7:0] wd;
    addr = iop_decode(bus.io_space, bus.addr);
    wr = bus.req && bus.wr;
    wr_ctrl = wr && (addr == IOP_CORE_CONTROL);
    wd = bus.wdata;
    state_next = state_reg;
    state_next.port_a.pins_in = a_pins_sync;
    state_next.port_b.pins_in = b_pins_sync;

    // Port registers.
    // A pin input write flips latch bits instead of storing the byte.
    if (wr && addr == IOP_PORT_A_DIRECTION) begin
      state_next.port_a.direction = wd;
    end else if (wr && addr == IOP_PORT_A_OUTPUT_LATCH) begin
      state_next.port_a.output_latch = wd;
    end else if (wr && addr == IOP_PORT_A_PIN_INPUT) begin
      state_next.port_a.output_latch = state_reg.port_a.output_latch ^ wd;
    end else if (wr && addr == IOP_PORT_B_DIRECTION) begin
      state_next.port_b.direction = wd;
    end else if (wr && addr == IOP_PORT_B_OUTPUT_LATCH) begin
      state_next.port_b.output_latch = wd;
    end else if (wr && addr == IOP_PORT_B_PIN_INPUT) begin
      state_next.port_b.output_latch = state_reg.port_b.output_latch ^ wd;
    end

    // Debug port disable: second equal write inside the window changes it.
    // A single write only arms the window, so one stray store is harmless.
    // Software that writes back what it read keeps the bit as it is.
    state_next.debug_win = iop_dec(state_reg.debug_win);
    if (wr_ctrl) begin
      if (state_reg.debug_win != 3'h0 &&
          state_reg.debug_wval[IOP_BIT_DEBUG_PORT_DISABLE] == wd[IOP_BIT_DEBUG_PORT_DISABLE]) begin
        state_next.debug_port_disable = wd[IOP_BIT_DEBUG_PORT_DISABLE];
        state_next.debug_win = 3'h0;
      end else begin
        state_next.debug_wval = wd;
        state_next.debug_win = IOP_UNLOCK_CYCLES;
      end
    end
    state_next.debug_en = debug_port_fuse && !state_next.debug_port_disable;

    // Brownout sleep-off: unlock write, then set with unlock clear.
    // The unlock lasts only a short window, so the set pattern written
    // alone can never switch the detector off by accident.
    state_next.soff_unlock_win = iop_dec(state_reg.soff_unlock_win);
    if (state_reg.soff_unlock_win == 3'h1) begin
      state_next.brownout_sleep_off_unlock = 1'b0;
    end
    if (wr_ctrl) begin
      if (wd[IOP_BIT_BROWNOUT_SLEEP_OFF] && wd[IOP_BIT_BROWNOUT_SLEEP_OFF_UNLOCK]) begin
        state_next.brownout_sleep_off_unlock = 1'b1;
        state_next.soff_unlock_win = IOP_UNLOCK_CYCLES;
      end else if (wd[IOP_BIT_BROWNOUT_SLEEP_OFF] && state_reg.soff_unlock_win != 3'h0) begin
        state_next.brownout_sleep_off = 1'b1;
        state_next.brownout_sleep_off_unlock = 1'b0;
        state_next.soff_unlock_win = 3'h0;
        state_next.soff_delay = IOP_SOFF_DELAY_CYCLES;
      end else begin
        // Any other control write abandons a half-done sequence.
        state_next.brownout_sleep_off_unlock = 1'b0;
        state_next.soff_unlock_win = 3'h0;
      end
    end
    // The set bit waits out a fixed delay before the window opens.
    if (state_reg.soff_delay != 3'h0) begin
      state_next.soff_delay = iop_dec(state_reg.soff_delay);
      if (state_reg.soff_delay == 3'h1) begin
        state_next.soff_active = 1'b1;
        state_next.soff_active_cnt = IOP_SOFF_ACTIVE_CYCLES;
      end
    end
    // The window closes by itself; software cannot hold it open.
    if (state_reg.soff_active) begin
      state_next.soff_active_cnt = iop_dec(state_reg.soff_active_cnt);
      if (state_reg.soff_active_cnt == 3'h1) begin
        state_next.soff_active = 1'b0;
        state_next.brownout_sleep_off = 1'b0;
      end
    end
    // A sleep fixes the detector state for that whole sleep; it comes back
    // on with the first instruction once the window has gone.
    if (sleep_exec) begin
      state_next.detector_off = state_reg.soff_active;
    end else if (state_reg.detector_off && !state_reg.soff_active && instr_done) begin
      state_next.detector_off = 1'b0;
    end

    // Global pull-up off is a plain bit.
    if (wr_ctrl) begin
      state_next.global_pullup_off = wd[IOP_BIT_GLOBAL_PULLUP_OFF];
    end

    // Vector select sequence with interrupt blocking.
    // Interrupts stay blocked in both open and tail states, so the table
    // never moves under an interrupt that is being taken.
    case (state_reg.vec_state)
      IOP_VEC_IDLE: begin
        if (wr_ctrl && wd[IOP_BIT_VECTOR_CHANGE_UNLOCK]) begin
          state_next.vector_change_unlock = 1'b1;
          state_next.vec_win = IOP_UNLOCK_CYCLES;
          state_next.vec_state = IOP_VEC_OPEN;
        end
      end
      IOP_VEC_OPEN: begin
        state_next.vec_win = iop_dec(state_reg.vec_win);
        if (wr_ctrl && !wd[IOP_BIT_VECTOR_CHANGE_UNLOCK]) begin
          state_next.vector_table_select = wd[IOP_BIT_VECTOR_TABLE_SELECT];
          state_next.vector_change_unlock = 1'b0;
          state_next.vec_state = IOP_VEC_TAIL;
        end else if (state_reg.vec_win == 3'h1) begin
          state_next.vector_change_unlock = 1'b0;
          state_next.vec_state = IOP_VEC_IDLE;
        end
      end
      IOP_VEC_TAIL: begin
        if (instr_done) begin
          state_next.vec_state = IOP_VEC_IDLE;
        end
      end
      default: begin
        state_next.vec_state = IOP_VEC_IDLE;
      end
    endcase

    // Registered pull-ups.
    state_next.a_pullup = iop_pullup(state_next.port_a.direction, state_next.port_a.output_latch,
                                     state_next.global_pullup_off);
    state_next.b_pullup = iop_pullup(state_next.port_b.direction, state_next.port_b.output_latch,
                                     state_next.global_pullup_off);

    // Read data, zero for unmapped addresses.
    // A pin input read sees the synchronised pins, never the latch.
    state_next.rdata = 8'h00;
    if (bus.req && !bus.wr) begin
      if (addr == IOP_PORT_A_PIN_INPUT) begin
        state_next.rdata = state_reg.port_a.pins_in;
      end else if (addr == IOP_PORT_A_DIRECTION) begin
        state_next.rdata = state_reg.port_a.direction;
      end else if (addr == IOP_PORT_A_OUTPUT_LATCH) begin
        state_next.rdata = state_reg.port_a.output_latch;
      end else if (addr == IOP_PORT_B_PIN_INPUT) begin
        state_next.rdata = state_reg.port_b.pins_in;
      end else if (addr == IOP_PORT_B_DIRECTION) begin
        state_next.rdata = state_reg.port_b.direction;
      end else if (addr == IOP_PORT_B_OUTPUT_LATCH) begin
        state_next.rdata = state_reg.port_b.output_latch;
      end else if (addr == IOP_CORE_CONTROL) begin
        state_next.rdata = {state_reg.debug_port_disable, state_reg.brownout_sleep_off,
                            state_reg.brownout_sleep_off_unlock, state_reg.global_pullup_off,
                            2'b00, state_reg.vector_table_select,
                            state_reg.vector_change_unlock};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // All state resets to constants.
  // The struct is cleared first; named fields restate their reset values.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.port_a.direction <= IOP_PORT_RESET;
      state_reg.port_a.output_latch <= IOP_PORT_RESET;
      state_reg.port_b.direction <= IOP_PORT_RESET;
      state_reg.port_b.output_latch <= IOP_PORT_RESET;
      state_reg.debug_port_disable <= IOP_CTRL_RESET[IOP_BIT_DEBUG_PORT_DISABLE];
      state_reg.vec_state <= IOP_VEC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Vector base and lock-bit blocking; the global interrupt flag is not touched.
  // The lock terms are combinational so a section change blocks at once.
  assign vector_base = state_reg.vector_table_select ? BOOT_START : '0;
  assign irq_block = (state_reg.vec_state != IOP_VEC_IDLE) ||
                     (!exec_in_boot && state_reg.vector_table_select && app_lock_bit) ||
                     (exec_in_boot && !state_reg.vector_table_select && boot_lock_bit);
  assign rdata = state_reg.rdata;
  assign port_a_out = state_reg.port_a.output_latch;
  assign port_a_oe = state_reg.port_a.direction;
  assign port_a_pullup = state_reg.a_pullup;
  assign port_b_out = state_reg.port_b.output_latch;
  assign port_b_oe = state_reg.port_b.direction;
  assign port_b_pullup = state_reg.b_pullup;
  assign debug_port_enable = state_reg.debug_en;
  assign brownout_sleep_off_active = state_reg.soff_active;
  assign brownout_detector_off = state_reg.detector_off;
endmodule // iop_regs
`default_nettype wire

// File: verif/iop_pins_model.sv
// Purpose: Outside circuitry on the port A or port B pins.
// Assumes: A pin not driven by the port shows its pull-up or the outside level.
// Notes: The outside level is set once by the bench and kept for every scenario.
`timescale 1ns/1ps
`default_nettype none
module iop_pins_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] ext_level,
  output logic [7:0] pins
);
  // Driven bits follow the port, an enabled pull-up forces a released bit high.
  assign pins = (pin_oe & pin_out) | (~pin_oe & (pin_pullup | ext_level));
endmodule // iop_pins_model
`default_nettype wire

// File: verif/iop_regs_chk.sv
// Purpose: Timing checks on the ports of the register block.
// Assumes: BOOT_START is not zero, so a boot vector base is told apart.
// Notes: Only top level ports are watched.
`timescale 1ns/1ps
`default_nettype none
module iop_regs_chk #(
  parameter int ADDR_W = 16,
  parameter logic [ADDR_W-1:0] BOOT_START = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire iop_pkg::iop_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_a_pullup,
  input wire logic debug_port_fuse,
  input wire logic debug_port_enable,
  input wire logic sleep_exec,
  input wire logic brownout_sleep_off_active,
  input wire logic brownout_detector_off,
  input wire logic [ADDR_W-1:0] vector_base,
  input wire logic app_lock_bit,
  input wire logic boot_lock_bit,
  input wire logic exec_in_boot,
  input wire logic irq_block
);
  import iop_pkg::*;
  // Control register hits in either address space, and the lock condition.
  wire logic ctrl_hit = bus.req && (bus.addr == (bus.io_space ? IOP_CORE_CONTROL - IOP_IO_OFFSET : IOP_CORE_CONTROL));
  wire logic ctrl_wr = ctrl_hit && bus.wr;
  wire logic ctrl_rd = ctrl_hit && !bus.wr;
  wire logic soff_set = ctrl_wr && bus.wdata[6] && !bus.wdata[5];
  wire logic in_boot = vector_base != '0;
  wire logic lock_c = (in_boot && app_lock_bit && !exec_in_boot) || (!in_boot && boot_lock_bit && exec_in_boot);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_unlock;
    ctrl_wr && bus.wdata[0] && !irq_block;
  endsequence
  sequence s_quiet;
    (!bus.req && !lock_c) [*6];
  endsequence
  property p_unlock_block; s_unlock |=> irq_block; endproperty
  property p_unlock_end; s_unlock ##1 s_quiet |-> !irq_block; endproperty
  property p_lock; lock_c |-> irq_block; endproperty
  property p_vec; $changed(vector_base) |-> $past(ctrl_wr && !bus.wdata[0] && irq_block)
    && ((vector_base == BOOT_START) == $past(bus.wdata[1])); endproperty
  property p_dbg_fuse; !debug_port_fuse |=> !debug_port_enable; endproperty
  property p_dbg_twice; $fell(debug_port_enable) && $past(debug_port_fuse) |-> $past(ctrl_wr && bus.wdata[7]);
  endproperty
  property p_soff_rise; $rose(brownout_sleep_off_active) |-> $past(soff_set, 4); endproperty
  property p_soff_len; $rose(brownout_sleep_off_active) |-> brownout_sleep_off_active [*3] ##1
    !brownout_sleep_off_active; endproperty
  property p_bdo; $rose(brownout_detector_off) |-> $past(sleep_exec && brownout_sleep_off_active); endproperty
  property p_pullup; (port_a_pullup & (port_a_oe | ~port_a_out)) == 8'h00; endproperty
  property p_rsvd; ctrl_rd |=> rdata[3:2] == 2'b00; endproperty
  a_unlock_block: assert property (p_unlock_block) else $error("no block after unlock");
  a_unlock_end: assert property (p_unlock_end) else $error("block outlived unlock");
  a_lock: assert property (p_lock) else $error("lock did not block");
  a_vec: assert property (p_vec) else $error("vector base changed wrongly");
  a_dbg_fuse: assert property (p_dbg_fuse) else $error("debug port on without fuse");
  a_dbg_twice: assert property (p_dbg_twice) else $error("debug port off without write");
  a_soff_rise: assert property (p_soff_rise) else $error("sleep-off rose at wrong time");
  a_soff_len: assert property (p_soff_len) else $error("sleep-off length wrong");
  a_bdo: assert property (p_bdo) else $error("detector off without sleep");
  a_pullup: assert property (p_pullup) else $error("pull-up on a wrong pin");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read high");
endmodule // iop_regs_chk
bind iop_regs iop_regs_chk #(.ADDR_W(ADDR_W), .BOOT_START(BOOT_START)) i_iop_regs_chk (.clock, .rst_n, .bus,
  .rdata, .port_a_out, .port_a_oe, .port_a_pullup, .debug_port_fuse, .debug_port_enable, .sleep_exec,
  .brownout_sleep_off_active, .brownout_detector_off, .vector_base, .app_lock_bit, .boot_lock_bit,
  .exec_in_boot, .irq_block);
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the port and core control registers.
// Assumes: Bus inputs change at the falling edge; a bus task ends at one.
// Notes: A read leaves the request up; every write task lowers it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import iop_pkg::*;
  localparam logic [15:0] BOOT = 16'h3C00;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  iop_bus_s bus = '0;
  logic [7:0] rdata, pa, pb, a_out, a_oe, a_pu, b_out, b_oe, b_pu, rd;
  logic [7:0] ea = 8'h5A;
  logic [7:0] eb = 8'h00;
  logic fuse = 1'b1, slp = 1'b0, alk = 1'b0, blk = 1'b0, inb = 1'b0, idn = 1'b0;
  logic dbg_en, bso, bdo, irqb;
  logic [15:0] vb;
  int n_errors = 0;
  int checked = 0;
  // ---------------------------------------------------------------------------
  // Clock, design and pin models
  // ---------------------------------------------------------------------------
  always #25 clock = ~clock;
  iop_regs #(.ADDR_W(16), .BOOT_START(BOOT)) i_iop_regs (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .port_a_pins(pa), .port_b_pins(pb), .port_a_out(a_out), .port_a_oe(a_oe), .port_a_pullup(a_pu),
    .port_b_out(b_out), .port_b_oe(b_oe), .port_b_pullup(b_pu), .debug_port_fuse(fuse),
    .debug_port_enable(dbg_en), .sleep_exec(slp), .brownout_sleep_off_active(bso), .brownout_detector_off(bdo),
    .vector_base(vb), .app_lock_bit(alk), .boot_lock_bit(blk), .exec_in_boot(inb), .instr_done(idn),
    .irq_block(irqb));
  iop_pins_model i_iop_pins_model_a (.pin_out(a_out), .pin_oe(a_oe), .pin_pullup(a_pu), .ext_level(ea), .pins(pa));
  iop_pins_model i_iop_pins_model_b (.pin_out(b_out), .pin_oe(b_oe), .pin_pullup(b_pu), .ext_level(eb), .pins(pb));
  // ---------------------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string msg);
    chk8({7'h00, got}, {7'h00, exp}, msg);
  endtask
  task automatic acc(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d);
    bus = '{1'b1, w, io, io ? a - IOP_IO_OFFSET : a, d};
    @(posedge clock);
    @(negedge clock);
    rd = rdata;
  endtask
  task automatic idle(input int n);
    bus.req = 1'b0;
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, io, a, d);
    idle(1);
  endtask
  task automatic w(input logic [7:0] d);
    wr(1'b1, IOP_CORE_CONTROL, d);
  endtask
  task automatic rdchk(input logic io, input logic [7:0] a, input logic [7:0] exp, input string msg);
    acc(1'b0, io, a, 8'h00);
    chk8(rd, exp, msg);
  endtask
  task automatic pulse_idn();
    idn = 1'b1;
    @(negedge clock);
    idn = 1'b0;
    @(negedge clock);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] regs [5];
    regs = '{IOP_PORT_A_DIRECTION, IOP_PORT_A_OUTPUT_LATCH, IOP_PORT_B_DIRECTION, IOP_PORT_B_OUTPUT_LATCH,
      IOP_CORE_CONTROL};
    for (int i = 0; i < 10; i++) begin
      rdchk(i[0], regs[i/2], 8'h00, "reset value");
    end
    rdchk(1'b0, 8'h30, 8'h00, "unmapped read");
    chk1(dbg_en, 1'b1, "debug port with fuse");
    idle(1);
    $display("test reset done");
  endtask
  task automatic t_ports();
    wr(1'b1, IOP_PORT_A_DIRECTION, 8'h0F);
    wr(1'b1, IOP_PORT_A_OUTPUT_LATCH, 8'hA5);
    chk8(a_oe, 8'h0F, "direction out");
    chk8(a_pu, 8'hA0, "pull-ups");
    idle(3);
    rdchk(1'b0, IOP_PORT_A_PIN_INPUT, 8'hF5, "pin levels");
    wr(1'b0, IOP_PORT_A_PIN_INPUT, 8'h3C);
    rdchk(1'b1, IOP_PORT_A_OUTPUT_LATCH, 8'h99, "toggled latch");
    wr(1'b0, IOP_PORT_B_DIRECTION, 8'hFF);
    wr(1'b0, IOP_PORT_B_OUTPUT_LATCH, 8'h81);
    idle(3);
    rdchk(1'b1, IOP_PORT_B_PIN_INPUT, 8'h81, "port b pins");
    wr(1'b0, IOP_PORT_B_DIRECTION, 8'hF0);
    chk8(b_pu, 8'h01, "port b pull-up");
    w(8'h1C);
    chk8(a_pu, 8'h00, "global pull-up off");
    chk8(b_pu, 8'h00, "port b pull-up off");
    rdchk(1'b0, IOP_CORE_CONTROL, 8'h10, "reserved bits");
    w(8'h00);
    chk8(a_pu, 8'h90, "pull-ups back");
    $display("test ports done");
  endtask
  task automatic t_debug();
    w(8'h80);
    idle(6);
    chk1(dbg_en, 1'b1, "single write ignored");
    w(8'h80);
    w(8'h80);
    chk1(dbg_en, 1'b0, "double write");
    rdchk(1'b0, IOP_CORE_CONTROL, 8'h80, "debug bit set");
    w(8'h00);
    w(8'h00);
    chk1(dbg_en, 1'b1, "debug port back");
    fuse = 1'b0;
    idle(2);
    chk1(dbg_en, 1'b0, "fuse off");
    fuse = 1'b1;
    idle(1);
    $display("test debug done");
  endtask
  task automatic t_soff();
    int n;
    w(8'h40);
    idle(8);
    chk1(bso, 1'b0, "no unlock");
    w(8'h60);
    w(8'h40);
    n = 0;
    while (bso !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    chk8(8'(n), 8'h02, "sleep-off delay");
    slp = 1'b1;
    @(negedge clock);
    slp = 1'b0;
    chk1(bdo, 1'b1, "detector off");
    @(negedge clock);
    chk1(bso, 1'b1, "still active");
    @(negedge clock);
    chk1(bso, 1'b0, "self clear");
    rdchk(1'b0, IOP_CORE_CONTROL, 8'h00, "bit cleared");
    idle(1);
    pulse_idn();
    chk1(bdo, 1'b0, "detector back on");
    slp = 1'b1;
    @(negedge clock);
    slp = 1'b0;
    chk1(bdo, 1'b0, "sleep outside window");
    $display("test brownout done");
  endtask
  task automatic t_vec();
    w(8'h01);
    chk1(irqb, 1'b1, "blocked on unlock");
    w(8'h02);
    chk1(vb === BOOT, 1'b1, "boot vectors");
    chk1(irqb, 1'b1, "blocked to next instr");
    pulse_idn();
    chk1(irqb, 1'b0, "released");
    rdchk(1'b0, IOP_CORE_CONTROL, 8'h02, "unlock cleared");
    w(8'h00);
    w(8'h01);
    idle(6);
    chk1(irqb, 1'b0, "block expired");
    chk1(vb === BOOT, 1'b1, "select kept");
    rdchk(1'b0, IOP_CORE_CONTROL, 8'h02, "unlock expired");
    idle(1);
    alk = 1'b1;
    @(negedge clock);
    chk1(irqb, 1'b1, "app lock");
    inb = 1'b1;
    @(negedge clock);
    chk1(irqb, 1'b0, "app lock in boot");
    alk = 1'b0;
    w(8'h01);
    w(8'h00);
    pulse_idn();
    chk1(vb === 16'h0000, 1'b1, "vectors back");
    blk = 1'b1;
    @(negedge clock);
    chk1(irqb, 1'b1, "boot lock");
    $display("test vectors done");
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_ports();
    t_debug();
    t_soff();
    t_vec();
    stop_test();
  end
  // Cuts a hang short and counts it as a mismatch.
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("unexpected at %0t: run limit reached", $time);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
